// File: logic/dspx_map.svh
// Purpose: Constants for the data space page extension block
// Assumes: 10-bit page selectors, 16-bit effective addresses
// Notes: Included by the package and the design
`ifndef DSPX_MAP_SVH
`define DSPX_MAP_SVH
`define DSPX_PAGE_W 10
`define DSPX_ADDR_W 16
`define DSPX_ADDR_TOP 15
`define DSPX_PAGE_ZERO 10'h000
`define DSPX_PAGE_ONE 10'h001
`define DSPX_XDATA_LAST 10'h1ff
`define DSPX_PSL_FIRST 10'h200
`define DSPX_PSL_LAST 10'h2ff
`define DSPX_PSU_FIRST 10'h300
`define DSPX_PSU_LAST 10'h3ff
`define DSPX_PAGE_RST 10'h001
`endif

// File: logic/dspx_pkg.sv
// Purpose: Types for the data space page extension block
// Assumes: Constants come from dspx_map.svh
// Notes: Mode and page class enumerations
`include "dspx_map.svh"
package dspx_pkg;
    typedef enum logic [2:0] {
        DSPX_MODE_DIRECT = 3'h0,
        DSPX_MODE_PREPOST = 3'h1,
        DSPX_MODE_REGOFS = 3'h2,
        DSPX_MODE_MODULO = 3'h3,
        DSPX_MODE_BITREV = 3'h4
    } dspx_mode_t;
    typedef enum logic [1:0] {
        DSPX_CLS_BASE = 2'h0,
        DSPX_CLS_XDATA = 2'h1,
        DSPX_CLS_PSL = 2'h2,
        DSPX_CLS_PSU = 2'h3
    } dspx_cls_t;
endpackage

// File: logic/dspx_page_ext.sv
// Purpose: Paged extension of the 16-bit data effective address
// Assumes: One access request per cycle, inputs synchronous to clock
// Notes: Results registered; page selectors updated on carry events
// Function
// - Separate page selectors for reads and for writes.
// - Read page may point at program space while write page at data.
// - One access moves data: source uses read page, destination write.
// - Paged carry clears address bit 15 before further handling.
// - Carry detected only from paged address in pre/post, offset, modulo or bit-reversed mode.
// - Overflow increments active page and sets address bit 15; the write page only when it is on a data page.
// - Underflow decrements active page and sets address bit 15.
// - Offset, modulo, bit-reversed carries set bit 15, page kept.
// - Boundary pages keep page, clear bit 15, address base space.
// - Extended access with page zero raises address error trap.
// - Writing program space through write page raises a trap.
`timescale 1ns/10ps
`include "dspx_map.svh"
module dspx_page_ext (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic page_wr_read,
    input wire logic page_wr_write,
    input wire logic [`DSPX_PAGE_W-1:0] page_wdata,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire dspx_pkg::dspx_mode_t acc_mode,
    input wire logic [`DSPX_ADDR_W-1:0] acc_base_addr,
    input wire logic [`DSPX_ADDR_W-1:0] acc_calc_addr,
    input wire logic acc_ovf,
    input wire logic acc_unf,
    output logic [`DSPX_PAGE_W-1:0] read_page_select,
    output logic [`DSPX_PAGE_W-1:0] write_page_select,
    output logic out_valid,
    output logic [`DSPX_ADDR_W-1:0] effective_address,
    output logic [`DSPX_PAGE_W-1:0] out_page,
    output logic out_paged,
    output logic out_program_space,
    output logic addr_error_trap
);
    import dspx_pkg::*;

    logic [`DSPX_PAGE_W-1:0] rpage_r;
    logic [`DSPX_PAGE_W-1:0] wpage_r;
    logic [`DSPX_PAGE_W-1:0] active_page_select;
    logic [`DSPX_PAGE_W-1:0] page_nxt;
    logic [`DSPX_ADDR_W-1:0] addr_nxt;
    logic paged_nxt;
    logic trap_nxt;
    logic carry_upd;
    dspx_cls_t cls;
    logic in_window;
    logic linear_mode;
    logic wrap_mode;

    function automatic dspx_cls_t page_class(
        input logic [`DSPX_PAGE_W-1:0] p);
        dspx_cls_t c;
        c = DSPX_CLS_BASE;
        if (p >= `DSPX_PSU_FIRST) begin
            c = DSPX_CLS_PSU;
        end else if (p >= `DSPX_PSL_FIRST) begin
            c = DSPX_CLS_PSL;
        end else if (p != `DSPX_PAGE_ZERO) begin
            c = DSPX_CLS_XDATA;
        end
        return c;
    endfunction

    // Write page for destinations, read page for sources
    assign active_page_select = acc_write ? wpage_r : rpage_r;
    assign cls = page_class(active_page_select);
    // Base address bit 15 marks the paged window before modification
    assign in_window = acc_base_addr[`DSPX_ADDR_TOP];
    assign linear_mode = (acc_mode == DSPX_MODE_PREPOST);
    assign wrap_mode = (acc_mode == DSPX_MODE_REGOFS) ||
                       (acc_mode == DSPX_MODE_MODULO) ||
                       (acc_mode == DSPX_MODE_BITREV);

    always_comb begin
        page_nxt = active_page_select;
        addr_nxt = acc_calc_addr;
        paged_nxt = acc_calc_addr[`DSPX_ADDR_TOP];
        trap_nxt = 1'b0;
        carry_upd = 1'b0;
        if (in_window && (acc_ovf || acc_unf) &&
            (linear_mode || wrap_mode)) begin
            addr_nxt[`DSPX_ADDR_TOP] = 1'b0;
            paged_nxt = 1'b0;
            if (wrap_mode) begin
                // Wrap within current page by setting bit 15 again, no page carry
                addr_nxt[`DSPX_ADDR_TOP] = 1'b1;
                paged_nxt = 1'b1;
            end else if (acc_ovf) begin
                // Last data page and last upper page fall back to base
                if (active_page_select != `DSPX_XDATA_LAST &&
                    active_page_select != `DSPX_PSU_LAST &&
                    !(acc_write && cls != DSPX_CLS_XDATA)) begin
                    page_nxt = active_page_select + `DSPX_PAGE_ONE;
                    addr_nxt[`DSPX_ADDR_TOP] = 1'b1;
                    paged_nxt = 1'b1;
                    carry_upd = 1'b1;
                end
            end else begin
                if (active_page_select != `DSPX_PAGE_ONE &&
                    active_page_select != `DSPX_PSL_FIRST) begin
                    page_nxt = active_page_select - `DSPX_PAGE_ONE;
                    addr_nxt[`DSPX_ADDR_TOP] = 1'b1;
                    paged_nxt = 1'b1;
                    carry_upd = 1'b1;
                end
            end
        end
        if (paged_nxt && page_nxt == `DSPX_PAGE_ZERO) begin
            trap_nxt = 1'b1;
        end
        if (paged_nxt && acc_write && page_nxt >= `DSPX_PSL_FIRST) begin
            trap_nxt = 1'b1;
        end
    end

    // Read page accepts any value, so program space reads work
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rpage_r <= `DSPX_PAGE_RST;
        end else if (acc_valid && !acc_write && carry_upd) begin
            rpage_r <= page_nxt;
        end else if (page_wr_read) begin
            rpage_r <= page_wdata;
        end
    end

    // Carry wins over a software load in the same cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wpage_r <= `DSPX_PAGE_RST;
        end else if (acc_valid && acc_write && carry_upd) begin
            wpage_r <= page_nxt;
        end else if (page_wr_write) begin
            wpage_r <= page_wdata;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            effective_address <= '0;
            out_page <= `DSPX_PAGE_ZERO;
            out_paged <= 1'b0;
            out_program_space <= 1'b0;
            addr_error_trap <= 1'b0;
        end else begin
            out_valid <= acc_valid;
            effective_address <= addr_nxt;
            out_page <= page_nxt;
            out_paged <= paged_nxt;
            out_program_space <= paged_nxt &&
                                 (page_nxt >= `DSPX_PSL_FIRST);
            addr_error_trap <= acc_valid && trap_nxt;
        end
    end

    assign read_page_select = rpage_r;
    assign write_page_select = wpage_r;

    // Carry checks stay generic so any page value exercises them
    a_ovf_increments: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && linear_mode && in_window && acc_ovf &&
        rpage_r != `DSPX_XDATA_LAST && rpage_r != `DSPX_PSU_LAST |=>
        rpage_r == $past(rpage_r) + `DSPX_PAGE_ONE &&
        effective_address[`DSPX_ADDR_TOP])
        else $error("Read page overflow did not increment");
    a_unf_decrements: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_write && linear_mode && in_window && acc_unf &&
        !acc_ovf && wpage_r != `DSPX_PAGE_ONE &&
        wpage_r != `DSPX_PSL_FIRST |=>
        wpage_r == $past(wpage_r) - `DSPX_PAGE_ONE &&
        effective_address[`DSPX_ADDR_TOP])
        else $error("Write page underflow did not decrement");
    a_wrap_keeps: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && wrap_mode && in_window && (acc_ovf || acc_unf) &&
        !page_wr_read && !page_wr_write |=> $stable(rpage_r) &&
        $stable(wpage_r) && effective_address[`DSPX_ADDR_TOP])
        else $error("Wrapping mode changed page or cleared bit 15");
    a_edge_base: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && linear_mode && in_window && acc_ovf &&
        !acc_unf && rpage_r == `DSPX_PSU_LAST |=>
        !effective_address[`DSPX_ADDR_TOP] && !out_paged)
        else $error("Last upper page overflow did not fall to base");
    a_psl_to_psu: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && linear_mode && in_window && acc_ovf &&
        !acc_unf && rpage_r == `DSPX_PSL_LAST |=>
        rpage_r == `DSPX_PSU_FIRST)
        else $error("Low word last page did not carry to upper page");
    a_page_zero: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_mode == DSPX_MODE_DIRECT &&
        acc_calc_addr[`DSPX_ADDR_TOP] &&
        active_page_select == `DSPX_PAGE_ZERO |=> addr_error_trap)
        else $error("Page zero access did not trap");
    a_ps_write: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_write && acc_mode == DSPX_MODE_DIRECT &&
        acc_calc_addr[`DSPX_ADDR_TOP] && wpage_r >= `DSPX_PSL_FIRST |=>
        addr_error_trap)
        else $error("Program space write did not trap");
    a_direction: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_write && !page_wr_read |=> $stable(rpage_r))
        else $error("Write access disturbed the read page");
    a_read_keeps_wr: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && !page_wr_write |=> $stable(wpage_r))
        else $error("Read access disturbed the write page");
    a_xdata_last: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && linear_mode && in_window && acc_ovf &&
        active_page_select == `DSPX_XDATA_LAST |=>
        !effective_address[`DSPX_ADDR_TOP] &&
        out_page == `DSPX_XDATA_LAST)
        else $error("Last data page overflow did not fall to base");
    a_unf_first: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && linear_mode && in_window && acc_unf &&
        !acc_ovf && !page_wr_read &&
        (rpage_r == `DSPX_PAGE_ONE || rpage_r == `DSPX_PSL_FIRST) |=>
        !effective_address[`DSPX_ADDR_TOP] && $stable(rpage_r))
        else $error("First page underflow did not fall to base");
    a_psu_to_psl: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && linear_mode && in_window && acc_unf &&
        !acc_ovf && rpage_r == `DSPX_PSU_FIRST |=>
        rpage_r == `DSPX_PSL_LAST && effective_address[`DSPX_ADDR_TOP])
        else $error("First upper page did not borrow to low word page");
    a_valid_follows: assert property (@(posedge clock)
        disable iff (sys_rst)
        1'b1 |=> out_valid == $past(acc_valid))
        else $error("Result valid does not follow the request");
    a_trap_valid: assert property (@(posedge clock)
        disable iff (sys_rst)
        addr_error_trap |-> out_valid)
        else $error("Trap raised without an access");
    a_ps_flag: assert property (@(posedge clock)
        disable iff (sys_rst)
        out_program_space |-> out_paged && out_page >= `DSPX_PSL_FIRST)
        else $error("Program space flag outside program pages");
    a_direct_still: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_mode == DSPX_MODE_DIRECT && !page_wr_read &&
        !page_wr_write |=> $stable(rpage_r) && $stable(wpage_r))
        else $error("Direct access moved a page selector");
    a_outside_still: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !in_window && !page_wr_read && !page_wr_write |=>
        $stable(rpage_r) && $stable(wpage_r))
        else $error("Unpaged base address moved a page selector");
    a_read_ps_ok: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && !acc_write && acc_mode == DSPX_MODE_DIRECT &&
        acc_calc_addr[`DSPX_ADDR_TOP] && rpage_r >= `DSPX_PSL_FIRST |=>
        !addr_error_trap && out_program_space)
        else $error("Program space read was refused");
    a_source_page: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_mode == DSPX_MODE_DIRECT |=>
        out_page == $past(active_page_select))
        else $error("Access used the wrong page selector");
    a_sw_load: assert property (@(posedge clock)
        disable iff (sys_rst)
        page_wr_read && !acc_valid |=> rpage_r == $past(page_wdata))
        else $error("Read page load did not take");
    a_base_no_trap: assert property (@(posedge clock)
        disable iff (sys_rst)
        acc_valid && acc_mode == DSPX_MODE_DIRECT &&
        !acc_calc_addr[`DSPX_ADDR_TOP] |=> !addr_error_trap)
        else $error("Base data space access trapped");
endmodule

// File: tb/dspx_agu_model.sv
// Purpose: Address generation model in front of the page extension
// Assumes: Small signed steps, one per access
// Notes: Carry flags only for paged base addresses
`timescale 1ns/10ps
module dspx_agu_model (
    input wire logic [15:0] base_addr,
    input wire logic [15:0] step,
    output logic [15:0] calc_addr,
    output logic ovf,
    output logic unf
);
    // Large steps would hide a carry, so only small ones are used
    assign calc_addr = base_addr + step;
    assign ovf = base_addr[15] & ~step[15] & ~calc_addr[15];
    assign unf = base_addr[15] & step[15] & ~calc_addr[15];
endmodule

// File: tb/tb_dspx_page_ext.sv
// Purpose: Self-checking bench for the page extension block
// Assumes: Inputs change on the falling edge
// Notes: Results sampled one falling edge after the request
`timescale 1ns/10ps
module tb_dspx_page_ext;
    import dspx_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic pw_rd = 1'b0;
    logic pw_wr = 1'b0;
    logic [9:0] pw_data = 10'h000;
    logic av = 1'b0;
    logic aw = 1'b0;
    dspx_mode_t am = DSPX_MODE_DIRECT;
    logic [15:0] ab = 16'h0000;
    logic [15:0] step = 16'h0000;
    logic [15:0] calc;
    logic ovf;
    logic unf;
    logic [9:0] rps;
    logic [9:0] wps;
    logic [9:0] opg;
    logic ov;
    logic opd;
    logic ops;
    logic trap;
    logic [15:0] eff;
    int err_count = 0;
    int check_count = 0;
    always #5 clock = ~clock;
    dspx_agu_model u_agu (.base_addr(ab), .step(step), .calc_addr(calc),
        .ovf(ovf), .unf(unf));
    dspx_page_ext u_dut (.clock(clock), .sys_rst(sys_rst),
        .page_wr_read(pw_rd), .page_wr_write(pw_wr), .page_wdata(pw_data),
        .acc_valid(av), .acc_write(aw), .acc_mode(am), .acc_base_addr(ab),
        .acc_calc_addr(calc), .acc_ovf(ovf), .acc_unf(unf),
        .read_page_select(rps), .write_page_select(wps), .out_valid(ov),
        .effective_address(eff), .out_page(opg), .out_paged(opd),
        .out_program_space(ops), .addr_error_trap(trap));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic rd, input logic [9:0] v);
        @(negedge clock);
        pw_rd = rd;
        pw_wr = !rd;
        pw_data = v;
        @(negedge clock);
        pw_rd = 1'b0;
        pw_wr = 1'b0;
    endtask
    task automatic acc(input logic w, input dspx_mode_t m,
        input logic [15:0] b, input logic [15:0] s);
        @(negedge clock);
        av = 1'b1;
        aw = w;
        am = m;
        ab = b;
        step = s;
        @(negedge clock);
        av = 1'b0;
        chk(16'(ov), 16'h0001);
    endtask
    task automatic t_reset();
        @(negedge clock);
        sys_rst = 1'b1;
        av = 1'b1;
        @(negedge clock);
        chk(16'({rps, wps[3:0]}), 16'h0011);
        chk(16'({ov, opd, ops, trap}), 16'h0000);
        sys_rst = 1'b0;
        av = 1'b0;
        @(negedge clock);
        chk(16'(ov), 16'h0000);
    endtask
    task automatic t_carry();
        load(1'b1, 10'h005);
        acc(1'b0, DSPX_MODE_PREPOST, 16'hfffe, 16'h0002);
        chk(eff, 16'h8000);
        chk(16'(opg), 16'h0006);
        chk(16'(rps), 16'h0006);
        acc(1'b0, DSPX_MODE_PREPOST, 16'h8000, 16'hfffe);
        chk(eff, 16'hfffe);
        chk(16'(rps), 16'h0005);
        load(1'b0, 10'h010);
        acc(1'b1, DSPX_MODE_PREPOST, 16'hfffe, 16'h0002);
        chk(16'(wps), 16'h0011);
        chk(16'(rps), 16'h0005);
        acc(1'b0, DSPX_MODE_DIRECT, 16'hfffe, 16'h0002);
        chk(16'(rps), 16'h0005);
        for (int m = 2; m <= 4; m++) begin
            acc(1'b0, dspx_mode_t'(m), 16'hfffe, 16'h0002);
            chk(eff, 16'h8000);
            chk(16'(rps), 16'h0005);
        end
    endtask
    task automatic t_bound();
        logic w[7] = '{0, 0, 0, 1, 0, 0, 0};
        logic u[7] = '{0, 0, 0, 0, 1, 1, 1};
        logic [9:0] pg[7] = '{'h1ff, 'h2ff, 'h3ff, 'h1ff, 'h001, 'h200, 'h300};
        logic [9:0] np[7] = '{'h1ff, 'h300, 'h3ff, 'h1ff, 'h001, 'h200, 'h2ff};
        logic e[7] = '{0, 1, 0, 0, 0, 0, 1};
        for (int i = 0; i < 7; i++) begin
            load(!w[i], pg[i]);
            acc(w[i], DSPX_MODE_PREPOST, u[i] ? 16'h8000 : 16'hfffe,
                u[i] ? 16'hfffe : 16'h0002);
            chk(16'(w[i] ? wps : rps), 16'(np[i]));
            chk(eff, {e[i], u[i] ? 15'h7ffe : 15'h0000});
        end
    endtask
    task automatic t_trap();
        load(1'b1, 10'h000);
        acc(1'b0, DSPX_MODE_DIRECT, 16'h8000, 16'h0000);
        chk(16'(trap), 16'h0001);
        load(1'b1, 10'h250);
        load(1'b0, 10'h010);
        acc(1'b0, DSPX_MODE_DIRECT, 16'h8000, 16'h0000);
        chk(16'(opg), 16'h0250);
        chk(16'({ops, trap}), 16'h0002);
        acc(1'b1, DSPX_MODE_DIRECT, 16'h8000, 16'h0000);
        chk(16'({opg, ops, opd}), 16'h0041);
        load(1'b0, 10'h300);
        acc(1'b1, DSPX_MODE_DIRECT, 16'h8002, 16'h0000);
        chk(16'(trap), 16'h0001);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        chk(16'({rps, wps[3:0]}), 16'h0011);
        t_carry();
        t_bound();
        t_trap();
        t_reset();
        give_verdict();
    end
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
endmodule
